// ### design/otg_sys_regs_pkg.sv
// package for the otg voltage / system threshold register bank
// assumes an i2c front end that delivers one byte access per cycle
`default_nettype none
package otg_sys_regs_pkg;
    // byte addresses of the register port
    localparam logic [7:0] ADDR_OTG_LOW  = 8'h06;
    localparam logic [7:0] ADDR_OTG_HIGH = 8'h07;
    localparam logic [7:0] ADDR_VMIN_LOW = 8'h3e;
    localparam logic [7:0] ADDR_VMIN_HI  = 8'h3f;

    // otg voltage register
    localparam logic [15:0] OTG_RESET     = 16'h09c4;
    localparam int          OTG_CODE_LSB  = 2;
    localparam int          OTG_CODE_MSB  = 13;
    localparam logic [1:0]  OTG_RSVD_HIGH = 2'h3;
    localparam logic [7:0]  OTG_LOW_MASK  = 8'hfc;
    localparam int          OTG_STEP_MV   = 8;
    localparam int          OTG_MIN_MV    = 3000;
    localparam int          OTG_MAX_MV    = 24000;
    localparam logic [11:0] OTG_CODE_MIN  = 12'(OTG_MIN_MV / OTG_STEP_MV);
    localparam logic [11:0] OTG_CODE_MAX  = 12'(OTG_MAX_MV / OTG_STEP_MV);

    // vmin protect low byte fields
    localparam int         TH2_LSB        = 2;
    localparam int         TH2_MSB        = 7;
    localparam int         TRACK_BIT      = 1;
    localparam int         FRS_BIT        = 0;
    localparam logic [7:0] VMIN_RST_MULTI = 8'h6c;
    localparam logic [7:0] VMIN_RST_ONE   = 8'h04;
    localparam logic [5:0] TH2_ONE_CELL_MASK = 6'h07;
    localparam logic [7:0] VAP_RESET      = 8'h00;

    // threshold scale
    localparam logic [15:0] TH_OFFSET_MV = 16'd3200;
    localparam logic [15:0] TH_STEP_MV   = 16'd100;

    // timing
    localparam int CLK_MHZ          = 100;
    localparam int FRS_OFF_US       = 200;
    localparam int FRS_OFF_CYCLES   = FRS_OFF_US * CLK_MHZ;
    localparam int DEGLITCH_US      = 5;
    localparam int DEGLITCH_CYCLES  = DEGLITCH_US * CLK_MHZ;

    // one byte access from the serial front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } byte_req_t;
endpackage
`default_nettype wire

// ### design/low_deglitch.sv
// deglitch filter: output rises once the input has stood high n cycles
// assumes the input is synchronous to ref_clk
`default_nettype none
module low_deglitch #(
    parameter int HOLD_CYCLES = 500
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic level_in,
    output var  logic level_out
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);
    logic [CW-1:0] cnt_q;

    // count while the condition holds, drop at once when it ends
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q     <= '0;
            level_out <= 1'b0;
        end else if (!level_in) begin
            cnt_q     <= '0;
            level_out <= 1'b0;
        end else if (cnt_q == LAST) begin
            level_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule // low_deglitch
`default_nettype wire

// ### design/otg_voltage_sys_threshold_regs.sv
// register bank: otg voltage, second system threshold, swap enable
// assumes a serial front end giving byte accesses synchronous to ref_clk
// What this block does
// [RULE1] second threshold is six bits 7:2, weights 3200 mV down to 100 mV.
// [RULE2] threshold bits 6,5,3 reset to one multi-cell, zero single; bit2 one, bit7 zero.
// [RULE3] tracking enable substitutes first threshold for second; resets disabled.
// [RULE4] swap enable rising zero to one disables power stage about 200 us.
// [RULE5] high impedance enable forces swap enable to zero.
// [RULE6] host avoids changing swap enable while reverse output power is on.
// [RULE7] otg voltage is twelve bits 13:2, weights 16384 mV down to 8 mV.
// [RULE8] otg writes below 3 V or above 24 V are ignored.
// [RULE9] otg voltage register resets to 09c4.
// [RULE10] otg bits 15:14 read zero; writing one there is an invalid write.
// [RULE11] otg bits 1:0 read zero; written values have no effect.
// [RULE12] host writes otg high byte at 07h, low byte at 06h.
// [RULE13] threshold code gets a fixed 3.2 V offset.
// [RULE14] single-cell threshold writes keep only the low three code bits, so top out at 3.9 V.
// [RULE15] system low status after 5 us below the active threshold.
// [RULE16] cell-dependent reset values taken from cell config before first access.
`default_nettype none
module otg_voltage_sys_threshold_regs
    import otg_sys_regs_pkg::*;
#(
    parameter int FRS_OFF_COUNT = otg_sys_regs_pkg::FRS_OFF_CYCLES
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire otg_sys_regs_pkg::byte_req_t req,
    output var  logic [7:0]                rdata_q,
    output var  logic                      invalid_write_q,
    output var  logic                      ready_q,
    input  wire logic                      single_cell_cfg,
    input  wire logic                      high_impedance_enable,
    input  wire logic [5:0]                sys_low_threshold_one,
    input  wire logic [15:0]               sys_voltage_mv,
    output var  logic [11:0]               otg_voltage_code_q,
    output var  logic [15:0]               active_threshold_mv_q,
    output var  logic                      fast_role_swap_enable,
    output var  logic                      power_stage_disable_q,
    output var  logic                      system_low_status
);
    import otg_sys_regs_pkg::*;

    localparam int TW = $clog2(FRS_OFF_COUNT + 1);
    localparam logic [TW-1:0] FRS_LAST = TW'(FRS_OFF_COUNT - 1);

    logic [15:0]   otg_q;
    logic [7:0]    otg_low_stage_q;
    logic [7:0]    vmin_low_q;
    logic [7:0]    vap_q;
    logic          single_cell_q;
    logic [TW-1:0] frs_cnt_q;
    logic [11:0]   new_code;
    logic          otg_wr;
    logic          otg_ok;
    logic [5:0]    th2_wr;
    logic [5:0]    th_sel;
    logic          frs_wr_val;
    logic          below;

    // address hit for a given access kind
    function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] want);
        hit = en && (a == want);
    endfunction

    // candidate otg value formed from the staged low and new high byte
    assign otg_wr   = ready_q && hit(req.wr, req.addr, ADDR_OTG_HIGH); // RULE12
    assign new_code = {req.wdata[5:0], otg_low_stage_q[7:2]};
    assign otg_ok   = (req.wdata[7:6] & OTG_RSVD_HIGH) == 2'h0 // RULE10
                      && new_code >= OTG_CODE_MIN && new_code <= OTG_CODE_MAX; // RULE8

    // threshold write value; single cell keeps only the low three code bits
    assign th2_wr     = single_cell_q ? (req.wdata[TH2_MSB:TH2_LSB] & TH2_ONE_CELL_MASK) // RULE14
                                      : req.wdata[TH2_MSB:TH2_LSB];
    assign frs_wr_val = req.wdata[FRS_BIT] & ~high_impedance_enable; // RULE5

    // first cycle after release catches the cell strap and loads reset values
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_q       <= 1'b0;
            single_cell_q <= 1'b0;
        end else if (!ready_q) begin
            ready_q       <= 1'b1;
            single_cell_q <= single_cell_cfg; // RULE16
        end
    end

    // otg voltage: low byte staged, whole word committed on the high byte
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            otg_q           <= OTG_RESET; // RULE9
            otg_low_stage_q <= OTG_RESET[7:0];
            invalid_write_q <= 1'b0;
        end else begin
            invalid_write_q <= 1'b0;
            if (ready_q && hit(req.wr, req.addr, ADDR_OTG_LOW)) begin
                otg_low_stage_q <= req.wdata & OTG_LOW_MASK; // RULE11
            end
            if (otg_wr) begin
                if (otg_ok) begin
                    otg_q <= {2'h0, new_code, 2'h0}; // RULE7
                end else begin
                    invalid_write_q <= 1'b1; // RULE10
                end
            end
        end
    end

    // vmin protect bytes; threshold byte reset depends on cell count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vmin_low_q <= VMIN_RST_MULTI;
            vap_q      <= VAP_RESET;
        end else if (!ready_q) begin
            vmin_low_q <= single_cell_cfg ? VMIN_RST_ONE : VMIN_RST_MULTI; // RULE2
        end else begin
            if (hit(req.wr, req.addr, ADDR_VMIN_LOW)) begin
                vmin_low_q[TH2_MSB:TH2_LSB] <= th2_wr; // RULE1
                vmin_low_q[TRACK_BIT]       <= req.wdata[TRACK_BIT]; // RULE3
                vmin_low_q[FRS_BIT]         <= frs_wr_val;
            end else if (high_impedance_enable) begin
                vmin_low_q[FRS_BIT] <= 1'b0; // RULE5
            end
            if (hit(req.wr, req.addr, ADDR_VMIN_HI)) begin
                vap_q <= req.wdata;
            end
        end
    end

    // power stage off window after swap enable goes from zero to one
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frs_cnt_q             <= '0;
            power_stage_disable_q <= 1'b0;
            fast_role_swap_enable <= 1'b0;
        end else begin
            fast_role_swap_enable <= vmin_low_q[FRS_BIT];
            if (vmin_low_q[FRS_BIT] && !fast_role_swap_enable) begin
                frs_cnt_q             <= '0;
                power_stage_disable_q <= 1'b1; // RULE4
            end else if (power_stage_disable_q) begin
                if (frs_cnt_q == FRS_LAST) begin
                    power_stage_disable_q <= 1'b0; // RULE4
                end else begin
                    frs_cnt_q <= frs_cnt_q + 1'b1;
                end
            end
        end
    end

    // active threshold in millivolts and the output registers
    assign th_sel = vmin_low_q[TRACK_BIT] ? sys_low_threshold_one : vmin_low_q[TH2_MSB:TH2_LSB]; // RULE3
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_threshold_mv_q <= TH_OFFSET_MV;
            otg_voltage_code_q    <= OTG_RESET[OTG_CODE_MSB:OTG_CODE_LSB];
        end else begin
            active_threshold_mv_q <= TH_OFFSET_MV + 16'(th_sel * TH_STEP_MV); // RULE13
            otg_voltage_code_q    <= otg_q[OTG_CODE_MSB:OTG_CODE_LSB];
        end
    end

    // read back; unmapped addresses read zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            if (hit(req.rd, req.addr, ADDR_OTG_LOW))       rdata_q <= otg_q[7:0];
            else if (hit(req.rd, req.addr, ADDR_OTG_HIGH)) rdata_q <= otg_q[15:8];
            else if (hit(req.rd, req.addr, ADDR_VMIN_LOW)) rdata_q <= vmin_low_q;
            else if (hit(req.rd, req.addr, ADDR_VMIN_HI))  rdata_q <= vap_q;
            else                                           rdata_q <= 8'h00;
        end
    end

    // system low alert through the deglitch filter
    assign below = ready_q && (sys_voltage_mv < active_threshold_mv_q);
    low_deglitch #(
        .HOLD_CYCLES(DEGLITCH_CYCLES)
    ) u_sys_low (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .level_in (below),
        .level_out(system_low_status) // RULE15
    );
endmodule // otg_voltage_sys_threshold_regs
`default_nettype wire

// ### verif/otg_voltage_sys_threshold_regs_properties.sv
// checker for the otg voltage / system threshold register bank
// assumes it is bound into the bank and sees only the bank's ports
`default_nettype none
module otg_regs_checker #(
    parameter int FRS_OFF_COUNT = 20
) (
    input wire logic                        ref_clk,
    input wire logic                        rst_n,
    input wire otg_sys_regs_pkg::byte_req_t req,
    input wire logic [7:0]                  rdata_q,
    input wire logic                        invalid_write_q,
    input wire logic                        ready_q,
    input wire logic                        high_impedance_enable,
    input wire logic [15:0]                 sys_voltage_mv,
    input wire logic [11:0]                 otg_voltage_code_q,
    input wire logic [15:0]                 active_threshold_mv_q,
    input wire logic                        fast_role_swap_enable,
    input wire logic                        power_stage_disable_q,
    input wire logic                        system_low_status
);
    import otg_sys_regs_pkg::*;
    logic [15:0] off_cnt_q;
    logic [15:0] low_cnt_q;
    // run lengths of the stage-off pulse and of a low system voltage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt_q <= 16'h0000;
            low_cnt_q <= 16'h0000;
        end else begin
            off_cnt_q <= power_stage_disable_q ? off_cnt_q + 16'h0001 : 16'h0000;
            low_cnt_q <= (sys_voltage_mv < active_threshold_mv_q) ? low_cnt_q + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_ready_rise: assert property (!ready_q |=> ready_q)
        else $error("ready stayed low after reset");
    a_hiz_swap_off: assert property (high_impedance_enable |-> ##2 !fast_role_swap_enable)
        else $error("swap enable set under high impedance");
    a_swap_stage_off: assert property ($rose(fast_role_swap_enable) |-> ##[0:2] power_stage_disable_q)
        else $error("no stage off after swap enable");
    a_stage_off_len: assert property ($fell(power_stage_disable_q) |-> off_cnt_q == 16'(FRS_OFF_COUNT))
        else $error("stage off pulse length wrong");
    a_high_bits_invalid: assert property (req.wr && ready_q && req.addr == 8'h07 && req.wdata[7:6] != 2'h0
        |=> invalid_write_q)
        else $error("high reserved bits not flagged");
    a_invalid_cause: assert property (invalid_write_q |-> $past(req.wr && req.addr == 8'h07))
        else $error("invalid flag without high byte write");
    a_otg_code_range: assert property (otg_voltage_code_q >= 12'h177 && otg_voltage_code_q <= 12'hbb8)
        else $error("otg code out of range");
    a_low_rsvd_read: assert property (req.rd && req.addr == 8'h06 |=> rdata_q[1:0] == 2'h0)
        else $error("low reserved bits read nonzero");
    a_high_rsvd_read: assert property (req.rd && req.addr == 8'h07 |=> rdata_q[7:6] == 2'h0)
        else $error("high reserved bits read nonzero");
    a_thresh_scale: assert property (active_threshold_mv_q >= 16'hc80 && active_threshold_mv_q <= 16'h251c
        && active_threshold_mv_q % 16'h64 == 16'h0)
        else $error("threshold off the 100 mv grid");
    a_low_quiet: assert property ((sys_voltage_mv >= active_threshold_mv_q) [*4] |-> !system_low_status)
        else $error("low status while above threshold");
    a_low_deglitch: assert property ($rose(system_low_status) |-> low_cnt_q inside {[16'h1ef:16'h1f9]})
        else $error("low status deglitch time wrong");
    c_stage_off: cover property ($rose(power_stage_disable_q));
    c_invalid: cover property (invalid_write_q);
    c_low: cover property ($rose(system_low_status));
endmodule // otg_regs_checker
bind otg_voltage_sys_threshold_regs otg_regs_checker #(.FRS_OFF_COUNT(FRS_OFF_COUNT)) chk_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata_q(rdata_q), .invalid_write_q(invalid_write_q),
    .ready_q(ready_q), .high_impedance_enable(high_impedance_enable), .sys_voltage_mv(sys_voltage_mv),
    .otg_voltage_code_q(otg_voltage_code_q), .active_threshold_mv_q(active_threshold_mv_q),
    .fast_role_swap_enable(fast_role_swap_enable), .power_stage_disable_q(power_stage_disable_q),
    .system_low_status(system_low_status));
`default_nettype wire

// ### verif/host_model.sv
// host model: issues byte reads and writes to the register bank
// assumes the bank takes a request at the edge after it is raised
`default_nettype none
module host_model (
    input  wire logic                        ref_clk,
    input  wire logic [7:0]                  rdata,
    output var  otg_sys_regs_pkg::byte_req_t req
);
    timeunit 1ns;
    timeprecision 100ps;
    import otg_sys_regs_pkg::*;
    initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'h5a, wdata: 8'ha5};
    // one access, prompt or slow; released lines show junk, not the old value
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        repeat ($urandom_range(2, 0)) @(posedge ref_clk);
        @(posedge ref_clk);
        #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk);
        #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = rdata;
    endtask
    // low byte staged first, high byte commits the word
    task automatic wr_otg(input logic [15:0] v);
        logic [7:0] q;
        xfer(1'b1, 8'h06, v[7:0], q);
        xfer(1'b1, 8'h07, v[15:8], q);
    endtask
endmodule // host_model
`default_nettype wire

// ### verif/otg_voltage_sys_threshold_regs_tb_top.sv
// testbench for the otg voltage / system threshold register bank
// assumes host_model and the bound checker are compiled before it
`default_nettype none
module otg_voltage_sys_threshold_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import otg_sys_regs_pkg::*;
    localparam int OFF    = 20;
    localparam int LIM[6] = '{'h5dc, 'h2ee0, 'h5d8, 'h2ee7, 'h47d0, 'h87d0};
    logic        ref_clk = 1'b0, rst_n = 1'b0, cell1 = 1'b0, hiz = 1'b0;
    logic [5:0]  th1  = 6'h00;
    logic [15:0] vsys = 16'h2ee0;
    byte_req_t   req;
    logic [7:0]  rdata_q, q;
    logic [11:0] code;
    logic [15:0] act;
    logic        inv, rdy, frs, psd, low, bad;
    int          n_fail = 0, tests_run = 0, otg, vmin, w, n;
    otg_voltage_sys_threshold_regs #(.FRS_OFF_COUNT(OFF)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata_q(rdata_q), .invalid_write_q(inv),
        .ready_q(rdy), .single_cell_cfg(cell1), .high_impedance_enable(hiz), .sys_low_threshold_one(th1),
        .sys_voltage_mv(vsys), .otg_voltage_code_q(code), .active_threshold_mv_q(act),
        .fast_role_swap_enable(frs), .power_stage_disable_q(psd), .system_low_status(low));
    host_model host (.ref_clk(ref_clk), .rdata(rdata_q), .req(req));
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input int e);
        host.xfer(1'b0, a, 8'h00, q);
        chk({8'h00, q}, 16'(e));
    endtask
    task automatic do_reset(input logic one);
        rst_n = 1'b0;
        cell1 = one;
        repeat (16) @(posedge ref_clk);
        #1 rst_n = 1'b1;
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence: reset values, otg writes, threshold, swap, low status, single cell
    initial begin
        void'($urandom(32'hf5c2));
        do_reset(1'b0);
        rd(8'h06, 'hc4);
        rd(8'h07, 'h09);
        rd(8'h3e, 'h6c);
        // upper protect byte is a plain store; unmapped addresses read zero
        rd(8'h3f, 'h00);
        w = int'($urandom_range(255, 0));
        host.xfer(1'b1, 8'h3f, 8'(w), q);
        rd(8'h3f, w);
        rd(8'h5a, 'h00);
        chk(16'(code), 16'h271);
        chk(act, 16'h170c);
        otg = 'h09c4;
        for (int i = 0; i < 18; i++) begin
            w = (i < 6) ? LIM[i] : int'($urandom_range('hffff, 0));
            host.wr_otg(16'(w));
            n = (w >> 2) & 'hfff;
            bad = (w & 'hc000) != 0 || n < 375 || n > 3000;
            chk(16'(inv), 16'(bad));
            if (!bad) otg = w & 'h3ffc;
            rd(8'h06, otg & 'hff);
            rd(8'h07, otg >> 8);
            chk(16'(code), 16'(otg >> 2));
        end
        for (int i = 0; i < 4; i++) begin
            th1 = 6'($urandom_range(63, 0));
            vmin = ($urandom_range(63, 0) << 2) | ((i & 2) >> 0);
            host.xfer(1'b1, 8'h3e, 8'(vmin), q);
            rd(8'h3e, vmin);
            chk(act, 16'(3200 + 100 * ((vmin & 2) != 0 ? int'(th1) : vmin >> 2)));
        end
        // no reverse power is enabled here, so the swap bit may change
        host.xfer(1'b1, 8'h3e, 8'h01, q);
        n = 0;
        // sample just after each edge, once the pulse has settled
        repeat (OFF + 10) begin
            @(posedge ref_clk);
            #1 n += int'(psd);
        end
        chk(16'(n), 16'(OFF));
        chk(16'(frs), 16'h1);
        // stored swap bit is cleared by high impedance, then a new write is masked
        hiz = 1'b1;
        rd(8'h3e, 'h00);
        host.xfer(1'b1, 8'h3e, 8'h01, q);
        rd(8'h3e, 'h00);
        chk({14'h0, frs, psd}, 16'h0);
        hiz = 1'b0;
        vsys = 16'hc1c;
        repeat (450) @(posedge ref_clk);
        #1 chk(16'(low), 16'h0);
        repeat (60) @(posedge ref_clk);
        #1 chk(16'(low), 16'h1);
        vsys = 16'h2ee0;
        do_reset(1'b1);
        rd(8'h3e, 'h04);
        host.xfer(1'b1, 8'h3e, 8'hfc, q);
        rd(8'h3e, 'h1c);
        chk(act, 16'hf3c);
        finish_test();
    end
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        finish_test();
    end
endmodule // otg_voltage_sys_threshold_regs_tb_top
`default_nettype wire
